// >>> core/cpsr_defines.svh
// register map, field positions, codes and reset values of the copper control/status bank
// assumes inclusion by bare name from the package and the design modules
`ifndef CPSR_DEFINES_SVH
`define CPSR_DEFINES_SVH

// register addresses
`define CPSR_ADDR_MAIN_CTRL 8'h00
`define CPSR_ADDR_CTRL_ONE  8'h10
`define CPSR_ADDR_STAT_ONE  8'h11
`define CPSR_ADDR_IRQ_STAT  8'h1A
`define CPSR_ADDR_IRQ_MASK  8'h1B
`define CPSR_ADDR_PAIR_POL  8'h1C

// main control fields
`define CPSR_MAIN_RESET     15
`define CPSR_MAIN_ANEN      12
`define CPSR_MAIN_PDN       11
`define CPSR_MAIN_RESTART   9

// copper control one fields
`define CPSR_CTRL_XOVER_HI  6
`define CPSR_CTRL_XOVER_LO  5
`define CPSR_CTRL_PDN       2
`define CPSR_CTRL_POLDIS    1
`define CPSR_CTRL_JABDIS    0

// copper status one fields
`define CPSR_STAT_SPEED_HI  15
`define CPSR_STAT_SPEED_LO  14
`define CPSR_STAT_DUPLEX    13
`define CPSR_STAT_PAGE      12
`define CPSR_STAT_RESOLVED  11
`define CPSR_STAT_LINK      10
`define CPSR_STAT_TXPAUSE   9
`define CPSR_STAT_RXPAUSE   8
`define CPSR_STAT_MDIX      6
`define CPSR_STAT_SLEEP     4
`define CPSR_STAT_GLINK     3
`define CPSR_STAT_POL       1
`define CPSR_STAT_JAB       0

// speed and crossover encodings
`define CPSR_SPEED_1000     2'b10
`define CPSR_SPEED_100      2'b01
`define CPSR_SPEED_10       2'b00
`define CPSR_XOVER_AUTO     2'b11
`define CPSR_XOVER_MDIX     2'b01
`define CPSR_XOVER_MDI      2'b00
`define CPSR_XOVER_RSVD     2'b10

// reset values
`define CPSR_SPEED_RST      2'h2
`define CPSR_MDIX_RST       1'b1
`define CPSR_ANEN_RST       1'b1
`define CPSR_XOVER_RST      2'b11
`define CPSR_WORD_ZERO      16'h0000

// interrupt event positions
`define CPSR_EV_PAGE        0
`define CPSR_EV_LINK        1
`define CPSR_EV_RESOLVED    2
`define CPSR_EV_JABBER      3
`define CPSR_EV_COUNT       4

`endif

// >>> core/cpsr_pkg.sv
// types shared by the copper control/status bank and its bench
// assumes the defines header sits beside it
`include "cpsr_defines.svh"

package cpsr_pkg;

  // live status coming up from the copper core
  typedef struct packed {
    logic       linkUp;
    logic       anComplete;
    logic       pageRx;
    logic [1:0] speed;
    logic       duplex;
    logic       txPause;
    logic       rxPause;
    logic       autoMdix;
    logic       rxPolRev;
    logic [3:0] pairPol;
    logic       jabber;
    logic       sleep;
  } cpsr_phy_stat_t;

  // controls going down to the copper core
  typedef struct packed {
    logic powerDown;
    logic swReset;
    logic anRestart;
    logic anEnable;
    logic polForceNormal;
    logic jabberOn;
    logic autoXover;
    logic mdixSel;
  } cpsr_phy_ctrl_t;

endpackage

// >>> core/cpsr_irq.sv
// sticky event bits, their mask and the level interrupt
// assumes one-cycle event pulses and write-one-to-clear from the register port
`timescale 1ns/100ps
`include "cpsr_defines.svh"

module cpsr_irq #(
  parameter int N = `CPSR_EV_COUNT
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] events,
  input  wire logic         wrStat,
  input  wire logic         wrMask,
  input  wire logic [N-1:0] wrData,
  output logic      [N-1:0] statusOut,
  output logic      [N-1:0] maskOut,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic         irq;
  } cpsr_irq_state_t;

  cpsr_irq_state_t st_reg;
  cpsr_irq_state_t st_next;
  logic [N-1:0]    stsNext;

  // per bit: a new event beats a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign stsNext[i] = events[i] | (st_reg.status[i] & ~(wrStat & wrData[i]));
    end
  endgenerate

  // next state
  always_comb begin
    st_next        = st_reg;
    st_next.status = stsNext;
    if (wrMask) begin
      st_next.mask = wrData;
    end
    st_next.irq    = |(stsNext & st_next.mask);
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign statusOut = st_reg.status;
  assign maskOut   = st_reg.mask;
  assign irq       = st_reg.irq;

endmodule

// >>> core/cpsr_regs.sv
// copper port control and status register bank with event interrupt
// assumes a synchronous register port and status inputs synchronous to sys_clk
`timescale 1ns/100ps
`include "cpsr_defines.svh"

module cpsr_regs (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic [7:0]              regAddr,
  input  wire logic [15:0]             regWrData,
  input  wire logic                    regWrEn,
  input  wire logic                    regRdEn,
  output logic      [15:0]             regRdData,
  input  wire cpsr_pkg::cpsr_phy_stat_t phyStat,
  output cpsr_pkg::cpsr_phy_ctrl_t     phyCtrl,
  output logic                         irq
);

  typedef struct packed {
    logic                     anEnable;
    logic                     mainPdn;
    logic                     ctrlPdn;
    logic                     polDis;
    logic                     jabDis;
    logic [1:0]               xoverMode;
    logic [1:0]               xoverApplied;
    logic [1:0]               speed;
    logic                     duplex;
    logic                     txPause;
    logic                     rxPause;
    logic                     mdix;
    logic                     pageFlag;
    logic                     pdnPrev;
    logic                     linkPrev;
    logic                     resolvedPrev;
    logic                     jabPrev;
    cpsr_pkg::cpsr_phy_ctrl_t ctrl;
    logic [15:0]              rdData;
  } cpsr_state_t;

  cpsr_state_t st_reg;
  cpsr_state_t st_next;

  logic                        resolved;
  logic                        pdnNow;
  logic                        pdnExit;
  logic                        swResetReq;
  logic                        restartReq;
  logic                        is10Half;
  logic                        polShown;
  logic [`CPSR_EV_COUNT-1:0]   events;
  logic [`CPSR_EV_COUNT-1:0]   irqStatus;
  logic [`CPSR_EV_COUNT-1:0]   irqMask;
  logic [15:0]                 ctrlWord;
  logic [15:0]                 mainWord;
  logic [15:0]                 statWord;

  // address match, shared by write and read decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // crossover decode: true for automatic, and for the reserved code run as automatic
  function automatic logic xoverIsAuto(input logic [1:0] mode);
    xoverIsAuto = (mode == `CPSR_XOVER_AUTO) || (mode == `CPSR_XOVER_RSVD);
  endfunction

  // resolution and power state
  assign resolved   = !st_reg.anEnable || phyStat.anComplete;
  assign pdnNow     = st_reg.mainPdn || st_reg.ctrlPdn;
  assign pdnExit    = st_reg.pdnPrev && !pdnNow;
  assign swResetReq = (regWrEn && hit(regAddr, `CPSR_ADDR_MAIN_CTRL) &&
                       regWrData[`CPSR_MAIN_RESET]) || pdnExit;
  assign restartReq = (regWrEn && hit(regAddr, `CPSR_ADDR_MAIN_CTRL) &&
                       regWrData[`CPSR_MAIN_RESTART]) || pdnExit;

  // 10BASE-T half duplex from the live speed and duplex
  assign is10Half = (phyStat.speed == `CPSR_SPEED_10) && !phyStat.duplex;

  // polarity as shown: forced normal in 10BASE-T when polarity disable is set, zero in 1000BASE-T (per-pair field instead)
  always_comb begin
    if (phyStat.speed == `CPSR_SPEED_1000) begin
      polShown = 1'b0;
    end else if (st_reg.polDis && phyStat.speed == `CPSR_SPEED_10) begin
      polShown = 1'b0;
    end else begin
      polShown = phyStat.rxPolRev;
    end
  end

  // interrupt events: page, link change, resolution, jabber start
  always_comb begin
    events                    = '0;
    events[`CPSR_EV_PAGE]     = phyStat.pageRx;
    events[`CPSR_EV_LINK]     = phyStat.linkUp != st_reg.linkPrev;
    events[`CPSR_EV_RESOLVED] = resolved && !st_reg.resolvedPrev;
    events[`CPSR_EV_JABBER]   = phyStat.jabber && !st_reg.jabPrev;
  end

  // sticky event status, mask and level interrupt
  cpsr_irq #(
    .N (`CPSR_EV_COUNT)
  ) u_irq (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .events    (events),
    .wrStat    (regWrEn && hit(regAddr, `CPSR_ADDR_IRQ_STAT)),
    .wrMask    (regWrEn && hit(regAddr, `CPSR_ADDR_IRQ_MASK)),
    .wrData    (regWrData[`CPSR_EV_COUNT-1:0]),
    .statusOut (irqStatus),
    .maskOut   (irqMask),
    .irq       (irq)
  );

  // main control readback; reset and restart read as zero
  always_comb begin
    mainWord                   = `CPSR_WORD_ZERO;
    mainWord[`CPSR_MAIN_ANEN]  = st_reg.anEnable;
    mainWord[`CPSR_MAIN_PDN]   = st_reg.mainPdn;
  end

  // copper control one readback
  always_comb begin
    ctrlWord                                          = `CPSR_WORD_ZERO;
    ctrlWord[`CPSR_CTRL_XOVER_HI:`CPSR_CTRL_XOVER_LO] = st_reg.xoverMode;
    ctrlWord[`CPSR_CTRL_PDN]                          = st_reg.ctrlPdn;
    ctrlWord[`CPSR_CTRL_POLDIS]                       = st_reg.polDis;
    ctrlWord[`CPSR_CTRL_JABDIS]                       = st_reg.jabDis;
  end

  // copper status one readback
  always_comb begin
    statWord                                          = `CPSR_WORD_ZERO;
    statWord[`CPSR_STAT_SPEED_HI:`CPSR_STAT_SPEED_LO] = st_reg.speed;
    statWord[`CPSR_STAT_DUPLEX]                       = st_reg.duplex;
    statWord[`CPSR_STAT_PAGE]                         = st_reg.pageFlag;
    statWord[`CPSR_STAT_RESOLVED]                     = resolved;
    statWord[`CPSR_STAT_LINK]                         = phyStat.linkUp;
    statWord[`CPSR_STAT_TXPAUSE]                      = st_reg.txPause;
    statWord[`CPSR_STAT_RXPAUSE]                      = st_reg.rxPause;
    statWord[`CPSR_STAT_MDIX]                         = st_reg.mdix;
    statWord[`CPSR_STAT_SLEEP]                        = phyStat.sleep;
    statWord[`CPSR_STAT_GLINK]                        = phyStat.linkUp;
    statWord[`CPSR_STAT_POL]                          = polShown;
    statWord[`CPSR_STAT_JAB]                          = phyStat.jabber && st_reg.ctrl.jabberOn;
  end

  // next state
  always_comb begin
    st_next              = st_reg;
    st_next.pdnPrev      = pdnNow;
    st_next.linkPrev     = phyStat.linkUp;
    st_next.resolvedPrev = resolved;
    st_next.jabPrev      = phyStat.jabber;

    // register writes
    if (regWrEn) begin
      if (hit(regAddr, `CPSR_ADDR_MAIN_CTRL)) begin
        st_next.anEnable = regWrData[`CPSR_MAIN_ANEN];
        st_next.mainPdn  = regWrData[`CPSR_MAIN_PDN];
      end else if (hit(regAddr, `CPSR_ADDR_CTRL_ONE)) begin
        st_next.xoverMode = regWrData[`CPSR_CTRL_XOVER_HI:`CPSR_CTRL_XOVER_LO];
        st_next.ctrlPdn   = regWrData[`CPSR_CTRL_PDN];
        st_next.polDis    = regWrData[`CPSR_CTRL_POLDIS];
        st_next.jabDis    = regWrData[`CPSR_CTRL_JABDIS];
      end
    end

    // resolved fields are captured only while resolution holds
    if (resolved) begin
      st_next.speed   = phyStat.speed;
      st_next.duplex  = phyStat.duplex;
      st_next.txPause = phyStat.txPause;
      st_next.rxPause = phyStat.rxPause;
      if (xoverIsAuto(st_reg.xoverApplied)) begin
        st_next.mdix = phyStat.autoMdix;
      end else begin
        st_next.mdix = (st_reg.xoverApplied == `CPSR_XOVER_MDIX);
      end
    end

    // page flag: set beats the read clear
    if (phyStat.pageRx) begin
      st_next.pageFlag = 1'b1;
    end else if (regRdEn && hit(regAddr, `CPSR_ADDR_STAT_ONE)) begin
      st_next.pageFlag = 1'b0;
    end else if (swResetReq) begin
      st_next.pageFlag = 1'b0;
    end

    // software reset applies the pending crossover mode
    if (swResetReq) begin
      st_next.xoverApplied = st_next.xoverMode;
    end

    // controls to the copper core
    st_next.ctrl.powerDown      = st_next.mainPdn || st_next.ctrlPdn;
    st_next.ctrl.swReset        = swResetReq;
    st_next.ctrl.anRestart      = restartReq;
    st_next.ctrl.anEnable       = st_next.anEnable;
    st_next.ctrl.polForceNormal = st_next.polDis;
    st_next.ctrl.jabberOn       = !st_next.jabDis && is10Half;
    st_next.ctrl.autoXover      = xoverIsAuto(st_next.xoverApplied);
    st_next.ctrl.mdixSel        = st_next.xoverApplied == `CPSR_XOVER_MDIX;

    // read data, valid the cycle after the strobe only
    st_next.rdData = `CPSR_WORD_ZERO;
    if (regRdEn) begin
      if (hit(regAddr, `CPSR_ADDR_MAIN_CTRL)) begin
        st_next.rdData = mainWord;
      end else if (hit(regAddr, `CPSR_ADDR_CTRL_ONE)) begin
        st_next.rdData = ctrlWord;
      end else if (hit(regAddr, `CPSR_ADDR_STAT_ONE)) begin
        st_next.rdData = statWord;
      end else if (hit(regAddr, `CPSR_ADDR_IRQ_STAT)) begin
        st_next.rdData[`CPSR_EV_COUNT-1:0] = irqStatus;
      end else if (hit(regAddr, `CPSR_ADDR_IRQ_MASK)) begin
        st_next.rdData[`CPSR_EV_COUNT-1:0] = irqMask;
      end else if (hit(regAddr, `CPSR_ADDR_PAIR_POL)) begin
        st_next.rdData[3:0] = phyStat.pairPol;
      end
    end
  end

  // state register with reset values
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_reg                     <= '0;
      st_reg.anEnable            <= `CPSR_ANEN_RST;
      st_reg.xoverMode           <= `CPSR_XOVER_RST;
      st_reg.xoverApplied        <= `CPSR_XOVER_RST;
      st_reg.speed               <= `CPSR_SPEED_RST;
      st_reg.mdix                <= `CPSR_MDIX_RST;
      st_reg.ctrl.anEnable       <= `CPSR_ANEN_RST;
      st_reg.ctrl.autoXover      <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign phyCtrl   = st_reg.ctrl;

endmodule

// >>> dv/cpsr_regs_assertions.sv
// concurrent checks on the ports of the copper control/status bank
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/100ps

module cpsr_regs_assertions (
  input wire logic                     sys_clk,
  input wire logic                     reset_n,
  input wire logic [7:0]               regAddr,
  input wire logic [15:0]              regWrData,
  input wire logic                     regWrEn,
  input wire logic                     regRdEn,
  input wire logic [15:0]              regRdData,
  input wire cpsr_pkg::cpsr_phy_stat_t phyStat,
  input wire cpsr_pkg::cpsr_phy_ctrl_t phyCtrl,
  input wire logic                     irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // strobe of a status word read
  logic rdStat;
  assign rdStat = regRdEn && (regAddr == 8'h11);

  // power-down control paths
  AST_PDN_CTRL: assert property ($past(regWrEn && regAddr == 8'h10 && regWrData[2]) |->
    phyCtrl.powerDown) else $error("copper power-down bit ignored");
  AST_PDN_MAIN: assert property ($past(regWrEn && regAddr == 8'h00 && regWrData[11]) |->
    phyCtrl.powerDown) else $error("main power-down bit ignored");
  AST_WAKE: assert property ($fell(phyCtrl.powerDown) |=>
    phyCtrl.swReset && phyCtrl.anRestart) else $error("no reset and restart on wake");
  AST_SWR_PULSE: assert property (phyCtrl.swReset |=> !phyCtrl.swReset)
    else $error("software reset longer than one cycle");

  // jabber only in 10 half duplex and only when enabled
  AST_JAB_MODE: assert property (phyCtrl.jabberOn |->
    $past(phyStat.speed == 2'b00 && !phyStat.duplex)) else $error("jabber outside 10 half");
  AST_JAB_OFF: assert property ($past(regWrEn && regAddr == 8'h10 && regWrData[0], 2) &&
    !$past(regWrEn) |-> !phyCtrl.jabberOn) else $error("jabber on while disabled");

  // status word contents
  AST_POL_GIG: assert property ($past(rdStat && phyStat.speed == 2'b10) |->
    !regRdData[1]) else $error("polarity bit set at gigabit");
  AST_RESOLVED: assert property ($past(rdStat) |-> regRdData[11] ==
    $past(!phyCtrl.anEnable || phyStat.anComplete)) else $error("resolved bit wrong");
  AST_LINK: assert property ($past(rdStat) |-> regRdData[10] == $past(phyStat.linkUp) &&
    regRdData[3] == $past(phyStat.linkUp)) else $error("link bits wrong");
  AST_PAGE_CLR: assert property ($past(rdStat && !phyStat.pageRx, 3) &&
    $past(!phyStat.pageRx, 2) && $past(rdStat && !phyStat.pageRx) |-> !regRdData[12])
    else $error("page flag not cleared by read");
endmodule

bind cpsr_regs cpsr_regs_assertions i_chk (
  .sys_clk   (sys_clk),
  .reset_n   (reset_n),
  .regAddr   (regAddr),
  .regWrData (regWrData),
  .regWrEn   (regWrEn),
  .regRdEn   (regRdEn),
  .regRdData (regRdData),
  .phyStat   (phyStat),
  .phyCtrl   (phyCtrl),
  .irq       (irq)
);

// >>> dv/tb.sv
// self-checking bench for the copper control/status bank
// assumes the package and the design compiled before it
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end

module tb;
  logic                     sys_clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     regWrEn = 1'b0;
  logic                     regRdEn = 1'b0;
  logic                     irq;
  logic [7:0]               regAddr = 8'h00;
  logic [15:0]              regWrData = 16'h0000;
  logic [15:0]              regRdData;
  logic [15:0]              rdv;
  cpsr_pkg::cpsr_phy_stat_t st = '0;
  cpsr_pkg::cpsr_phy_ctrl_t ctl;
  int                       fails = 0;
  int                       cmp_count = 0;

  cpsr_regs i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .phyStat(st), .phyCtrl(ctl), .irq(irq));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  // one-cycle read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 rdv = regRdData;
  endtask

  // one-cycle page pulse
  task automatic page;
    @(posedge sys_clk);
    st.pageRx <= 1'b1;
    @(posedge sys_clk);
    st.pageRx <= 1'b0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // fields captured while resolved: speed, duplex, tx, rx, mdix
  function automatic logic [5:0] fld(input cpsr_pkg::cpsr_phy_stat_t s);
    return {s.speed, s.duplex, s.txPause, s.rxPause, s.autoMdix};
  endfunction

  // expected status word; c is {polarity disable, jabber disable}
  function automatic logic [15:0] expStat(input cpsr_pkg::cpsr_phy_stat_t s, input logic res,
                                          input logic [5:0] h, input logic [1:0] c);
    logic pol;
    logic jab;
    pol = (s.speed == 2'b10 || (s.speed == 2'b00 && c[1])) ? 1'b0 : s.rxPolRev;
    jab = s.jabber && !c[0] && s.speed == 2'b00 && !s.duplex;
    return {h[5:3], 1'b0, res, s.linkUp, h[2:1], 1'b0, h[0], 1'b0, s.sleep, s.linkUp, 1'b0,
            pol, jab};
  endfunction

  // main sequence
  initial begin
    logic [5:0]               h;
    logic [1:0]               c;
    logic                     an;
    logic [31:0]              rnd;
    cpsr_pkg::cpsr_phy_stat_t s;
    int                       k;
    void'($urandom(32'hcf13e270));
    h = 6'b100001;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values and an unmapped read
    rd(8'h10); `CHK("ctrl reset", 16'h0060, rdv)
    rd(8'h11); `CHK("stat reset", 16'h8040, rdv)
    rd(8'h05); `CHK("unmapped", 16'h0000, rdv)
    $display("test reset done");
    // power down by either bit, wake only when both clear
    wr(8'h10, 16'h0064); #1 `CHK("pdn ctrl", 1'b1, ctl.powerDown)
    wr(8'h00, 16'h1800);
    wr(8'h10, 16'h0060); #1 `CHK("pdn main", 1'b1, ctl.powerDown)
    wr(8'h00, 16'h1000);
    #1;
    for (k = 0; k < 4 && ctl.swReset !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 4) begin
      fails++;
      test_done();
    end
    `CHK("wake restart", 1'b1, ctl.anRestart)
    `CHK("wake state", 1'b0, ctl.powerDown)
    $display("test power done");
    // random status with random negotiation enable and control bits
    for (int i = 0; i < 30; i++) begin
      rnd = $urandom;
      an = rnd[16];
      c = rnd[18:17];
      wr(8'h00, {3'b000, an, 12'h000});
      wr(8'h10, {14'h0018, c});
      if (!an || st.anComplete) h = fld(st);
      s = rnd[15:0];
      s.pageRx = 1'b0;
      @(posedge sys_clk);
      st <= s;
      @(posedge sys_clk);
      if (!an || s.anComplete) h = fld(s);
      rd(8'h11); `CHK("status", expStat(s, !an || s.anComplete, h, c), rdv)
    end
    $display("test random status done");
    // every crossover mode applied by software reset
    for (int m = 0; m < 4; m++) begin
      wr(8'h10, {9'h000, 2'(m), 5'h00});
      wr(8'h00, 16'h8000);
      @(posedge sys_clk);
      rd(8'h11); `CHK("mdix", (m == 1) ? 1'b1 : (m == 0) ? 1'b0 : st.autoMdix, rdv[6])
    end
    $display("test crossover done");
    // page flag, read clear, set during read, interrupt mask and clear
    wr(8'h1B, 16'h0001);
    page();
    #1;
    for (k = 0; k < 4 && irq !== 1'b1; k++) @(posedge sys_clk);
    #1 `CHK("irq raised", 1'b1, irq)
    rd(8'h11); `CHK("page set", 1'b1, rdv[12])
    rd(8'h11); `CHK("page cleared", 1'b0, rdv[12])
    @(posedge sys_clk);
    st.pageRx <= 1'b1;
    regAddr <= 8'h11;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    st.pageRx <= 1'b0;
    regRdEn <= 1'b0;
    rd(8'h11); `CHK("page kept", 1'b1, rdv[12])
    rd(8'h1A); `CHK("irq status", 1'b1, rdv[0])
    wr(8'h1A, 16'h0001);
    @(posedge sys_clk);
    #1 `CHK("irq cleared", 1'b0, irq)
    wr(8'h1B, 16'h0000);
    page();
    repeat (3) @(posedge sys_clk);
    #1 `CHK("irq masked", 1'b0, irq)
    rd(8'h1A); `CHK("masked status", 1'b1, rdv[0])
    $display("test page and interrupt done");
    test_done();
  end
endmodule
